// ### pkg/sleep_ctrl_pkg.sv
package sleep_ctrl_pkg;
  // register byte addresses on the APB bus
  localparam logic [7:0] mcu_control_addr = 8'h00;
  localparam logic [7:0] sleep_status_addr = 8'h04;
  localparam logic [7:0] mcu_control_reset = 8'h00;
  // mcu_control field positions
  localparam int sleep_enable_bit = 5;
  localparam int sleep_kind_lo = 2;
  localparam int sleep_kind_hi = 4;
  // sleep_status field positions
  localparam int stat_state_lo = 0;
  localparam int stat_mode_lo = 2;
  localparam int stat_cause_bit = 5;
  // sleep_kind_field codes
  localparam logic [2:0] kind_idle = 3'h0;
  localparam logic [2:0] kind_adc_nr = 3'h1;
  localparam logic [2:0] kind_power_down = 3'h2;
  localparam logic [2:0] kind_power_save = 3'h3;
  localparam logic [2:0] kind_reserved_a = 3'h4;
  localparam logic [2:0] kind_reserved_b = 3'h5;
  localparam logic [2:0] kind_standby = 3'h6;
  localparam logic [2:0] kind_ext_standby = 3'h7;
  // wake timing in core clock cycles
  localparam int wake_extra_cycles = 4;
  localparam int standby_wake_cycles = 6;
  localparam int wake_count_width = 17;
  localparam int startup_width = 16;
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_sleep = 2'b01,
    st_wake = 2'b10
  } sleep_state_t;
endpackage

// ### hw/sleep_mode_controller.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module sleep_mode_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_exec,
  input wire logic crystal_clock_selected,
  input wire logic [sleep_ctrl_pkg::startup_width-1:0] startup_cycles,
  input wire logic adc_enabled,
  input wire logic timer0_external_crystal_clocking,
  input wire logic global_irq_enable,
  input wire logic timer0_ovf_irq_enable,
  input wire logic timer0_cmp_irq_enable,
  input wire logic timer0_ovf_event,
  input wire logic timer0_cmp_event,
  input wire logic adc_done_irq,
  input wire logic twi_addr_match_irq,
  input wire logic spm_ee_ready_irq,
  input wire logic other_io_irq,
  input wire logic [3:0] ext_irq_low_group,
  input wire logic [3:0] ext_irq_high_group,
  input wire logic ext_irq_high_level_mode,
  input wire logic reset_source,
  output logic core_hold,
  output logic core_clock_en,
  output logic program_memory_clock_en,
  output logic io_clock_en,
  output logic converter_clock_en,
  output logic async_clock_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic adc_auto_start,
  output logic irq_resume,
  output logic reset_vector_req
);
  import sleep_ctrl_pkg::*;

  logic [7:0] mcu_control;
  sleep_state_t state;
  logic [2:0] active_kind;
  logic wake_by_reset;
  logic [wake_count_width-1:0] wake_count;
  logic [3:0] low_meta, low_sync, high_meta, high_sync;
  logic rst_meta, rst_sync;
  logic sleep_enable;
  logic [2:0] sleep_kind_field;
  logic kind_ok, enter_sleep;
  logic timer0_wake, ext_wake, irq_wake;
  logic [wake_count_width-1:0] next_wake_count;
  logic wr_en, rd_en;

  assign sleep_enable = mcu_control[sleep_enable_bit];
  assign sleep_kind_field = mcu_control[sleep_kind_hi:sleep_kind_lo];

  // pins from outside the clock domain pass two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_meta <= 4'h0;
      low_sync <= 4'h0;
      high_meta <= 4'h0;
      high_sync <= 4'h0;
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      low_meta <= ext_irq_low_group;
      low_sync <= low_meta;
      high_meta <= ext_irq_high_group;
      high_sync <= high_meta;
      rst_meta <= reset_source;
      rst_sync <= rst_meta;
    end
  end

  // apb slave: zero wait states, unmapped addresses answer with an error
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcu_control <= mcu_control_reset;
    end else if (wr_en && paddr == mcu_control_addr) begin
      mcu_control <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= paddr != mcu_control_addr && paddr != sleep_status_addr;
      prdata <= 32'h0;
      if (!pwrite && paddr == mcu_control_addr) begin
        prdata <= {24'h0, mcu_control};
      end else if (!pwrite && paddr == sleep_status_addr) begin
        prdata <= {26'h0, wake_by_reset, active_kind, state};
      end
    end
  end

  // standby codes need a crystal; reserved codes never sleep
  always_comb begin
    unique case (sleep_kind_field)
      kind_idle, kind_adc_nr, kind_power_down, kind_power_save:
        kind_ok = 1'b1;
      kind_standby, kind_ext_standby:
        kind_ok = crystal_clock_selected;
      default:
        kind_ok = 1'b0;
    endcase
  end

  assign enter_sleep = (state == st_run) && sleep_exec && sleep_enable
    && kind_ok;

  assign timer0_wake = global_irq_enable
    && ((timer0_ovf_event && timer0_ovf_irq_enable)
    || (timer0_cmp_event && timer0_cmp_irq_enable));
  // high group wakes the deep modes only in level mode
  assign ext_wake = |low_sync || (ext_irq_high_level_mode && |high_sync);

  always_comb begin
    unique case (active_kind)
      kind_idle:
        irq_wake = |low_sync || |high_sync || twi_addr_match_irq
          || timer0_wake || spm_ee_ready_irq || adc_done_irq
          || other_io_irq;
      kind_adc_nr:
        irq_wake = adc_done_irq || ext_wake || twi_addr_match_irq
          || timer0_wake || spm_ee_ready_irq;
      kind_power_save, kind_ext_standby:
        irq_wake = ext_wake || twi_addr_match_irq
          || (timer0_external_crystal_clocking && timer0_wake);
      default:
        irq_wake = ext_wake || twi_addr_match_irq;
    endcase
  end

  // wake delay: oscillator restart time plus the fixed core hold
  always_comb begin
    unique case (active_kind)
      kind_idle, kind_adc_nr:
        next_wake_count = wake_count_width'(wake_extra_cycles);
      kind_standby, kind_ext_standby:
        next_wake_count = wake_count_width'(standby_wake_cycles
          + wake_extra_cycles);
      default:
        next_wake_count = wake_count_width'({1'b0, startup_cycles})
          + wake_count_width'(wake_extra_cycles);
    endcase
  end

  // only the clock gating changes; storage is never cleared here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_run;
      active_kind <= kind_idle;
      wake_by_reset <= 1'b0;
      wake_count <= '0;
    end else begin
      unique case (state)
        st_run: begin
          if (enter_sleep) begin
            state <= st_sleep;
            active_kind <= sleep_kind_field;
          end
        end
        st_sleep: begin
          if (rst_sync) begin
            state <= st_wake;
            wake_by_reset <= 1'b1;
            wake_count <= next_wake_count;
          end else if (irq_wake) begin
            state <= st_wake;
            wake_by_reset <= 1'b0;
            wake_count <= next_wake_count;
          end
        end
        st_wake: begin
          if (rst_sync) begin
            wake_by_reset <= 1'b1;
          end
          if (wake_count <= wake_count_width'(1)) begin
            state <= st_run;
            wake_count <= '0;
          end else begin
            wake_count <= wake_count - wake_count_width'(1);
          end
        end
        default: state <= st_run;
      endcase
    end
  end

  // one-cycle pulses at entry and at the end of the wake delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_auto_start <= 1'b0;
      irq_resume <= 1'b0;
      reset_vector_req <= 1'b0;
    end else begin
      adc_auto_start <= enter_sleep && adc_enabled
        && (sleep_kind_field == kind_idle
        || sleep_kind_field == kind_adc_nr);
      irq_resume <= state == st_wake && wake_count <= wake_count_width'(1)
        && !wake_by_reset && !rst_sync;
      reset_vector_req <= state == st_wake
        && wake_count <= wake_count_width'(1)
        && (wake_by_reset || rst_sync);
    end
  end

  // registered gates so the clock tree sees no combinational glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clock_en <= 1'b1;
      program_memory_clock_en <= 1'b1;
      io_clock_en <= 1'b1;
      converter_clock_en <= 1'b1;
      async_clock_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= 1'b0;
    end else if (enter_sleep) begin
      core_clock_en <= 1'b0;
      program_memory_clock_en <= 1'b0;
      io_clock_en <= sleep_kind_field == kind_idle;
      converter_clock_en <= sleep_kind_field == kind_idle
        || sleep_kind_field == kind_adc_nr;
      async_clock_en <= sleep_kind_field == kind_idle
        || sleep_kind_field == kind_adc_nr
        || (timer0_external_crystal_clocking
        && (sleep_kind_field == kind_power_save
        || sleep_kind_field == kind_ext_standby));
      main_osc_en <= sleep_kind_field == kind_idle
        || sleep_kind_field == kind_adc_nr
        || sleep_kind_field == kind_standby
        || sleep_kind_field == kind_ext_standby;
      timer_osc_en <= timer0_external_crystal_clocking
        && sleep_kind_field != kind_power_down
        && sleep_kind_field != kind_standby;
    end else if (state == st_sleep && (rst_sync || irq_wake)) begin
      io_clock_en <= 1'b1;
      converter_clock_en <= 1'b1;
      async_clock_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= timer0_external_crystal_clocking;
    end else if (state == st_wake && wake_count <= wake_count_width'(1)) begin
      core_clock_en <= 1'b1;
      program_memory_clock_en <= 1'b1;
    end else if (state == st_run) begin
      timer_osc_en <= timer0_external_crystal_clocking;
    end
  end

  assign core_hold = state != st_run;

  sequence s_enter;
    state == st_run && sleep_exec && sleep_enable && kind_ok;
  endsequence

  sequence s_irq_wake_idle;
    state == st_sleep && active_kind == kind_idle && irq_wake && !rst_sync;
  endsequence

  sleep_needs_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_run && sleep_exec && !sleep_enable |=> state == st_run)
    else $error("sleep entered without sleep_enable");
  reserved_kind_nop_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_run && sleep_exec && (sleep_kind_field == kind_reserved_a
    || sleep_kind_field == kind_reserved_b) |=> !core_hold)
    else $error("reserved sleep code halted the core");
  standby_no_xtal_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_run && sleep_exec && sleep_kind_field == kind_standby
    && !crystal_clock_selected |=> state == st_run)
    else $error("standby entered without crystal");
  idle_clock_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_enter ##0 sleep_kind_field == kind_idle |=> !core_clock_en
    && !program_memory_clock_en && io_clock_en && converter_clock_en)
    else $error("idle clock gating wrong");
  adc_nr_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_enter ##0 sleep_kind_field == kind_adc_nr |=> !io_clock_en
    && converter_clock_en && main_osc_en)
    else $error("noise mode clock gating wrong");
  power_down_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_enter ##0 sleep_kind_field == kind_power_down |=> !main_osc_en
    && !async_clock_en && !converter_clock_en)
    else $error("power-down left a clock running");
  standby_osc_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_enter ##0 sleep_kind_field == kind_standby |=> main_osc_en
    && !io_clock_en)
    else $error("standby oscillator not kept");
  idle_wake_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_irq_wake_idle |=> core_hold [*4] ##1 !core_hold && irq_resume)
    else $error("idle wake hold not four cycles");
  adc_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_enter ##0 adc_enabled && sleep_kind_field == kind_adc_nr
    |=> adc_auto_start)
    else $error("conversion not started on entry");
  reset_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_sleep && rst_sync && active_kind == kind_idle
    |=> ##4 reset_vector_req && !irq_resume)
    else $error("reset during sleep missed the vector");
  deep_wake_filter_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_sleep && active_kind == kind_power_down && !rst_sync
    && !twi_addr_match_irq && !(|low_sync) && !(|high_sync) |=> state == st_sleep)
    else $error("power-down woke on a disallowed source");
  timer0_gie_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_sleep && active_kind == kind_power_save && !global_irq_enable
    && !rst_sync && !twi_addr_match_irq && !ext_wake |=> state == st_sleep)
    else $error("timer 0 woke without global enable");
endmodule

// ### verification/core_model.sv
`timescale 1ns/100ps
// stands in for the core: one sleep pulse per request, none while held
module core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic exec_req,
  input wire logic core_hold,
  output logic sleep_exec
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_exec <= 1'b0;
    end else begin
      sleep_exec <= exec_req && !sleep_exec && !core_hold;
    end
  end
endmodule

// ### verification/tb.sv
`timescale 1ns/100ps
module tb;
  import sleep_ctrl_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sleep_exec, exec_req = 0, xtal = 0, adc_en = 1;
  logic gie = 1, core_hold, ce, pme, ioe, cve, ase, moe, toe;
  logic adc_st, res_p, rv_p, seen_res = 0, seen_rv = 0, seen_adc = 0;
  logic [7:0] src = 8'h00;
  logic [15:0] sut = 16'h0014;
  wire logic [6:0] ens = {ce, pme, ioe, cve, ase, moe, toe};
  int n_errors = 0, checks = 0;
  logic [2:0] t_code[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h3, 3'h0};
  // the first idle row wakes on other io, the last idle row on the reset source
  int t_src[8] = '{0, 1, 2, 3, 5, 4, 6, 6};
  int t_bad[8] = '{-1, 0, 7, 1, 0, 1, 3, -1};
  logic [6:0] t_en[8] = '{7'h1f, 7'h0f, 7'h00, 7'h05, 7'h02, 7'h07, 7'h05,
                          7'h1f};
  int t_dly[8] = '{4, 4, 24, 24, 10, 10, 24, 4};

  always #12.5 pclk = ~pclk;

  sleep_mode_controller dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
    .crystal_clock_selected(xtal), .startup_cycles(sut),
    .adc_enabled(adc_en), .timer0_external_crystal_clocking(1'b1),
    .global_irq_enable(gie), .timer0_ovf_irq_enable(1'b1),
    .timer0_cmp_irq_enable(1'b1), .timer0_ovf_event(src[3]),
    .timer0_cmp_event(src[4]), .adc_done_irq(src[1]),
    .twi_addr_match_irq(src[2]), .spm_ee_ready_irq(src[7]),
    .other_io_irq(src[0]), .ext_irq_low_group({3'h0, src[5]}),
    .ext_irq_high_group(4'h0), .ext_irq_high_level_mode(1'b0),
    .reset_source(src[6]), .core_hold(core_hold), .core_clock_en(ce),
    .program_memory_clock_en(pme), .io_clock_en(ioe),
    .converter_clock_en(cve), .async_clock_en(ase), .main_osc_en(moe),
    .timer_osc_en(toe), .adc_auto_start(adc_st), .irq_resume(res_p),
    .reset_vector_req(rv_p)
  );

  core_model core_u (
    .pclk(pclk), .presetn(presetn), .exec_req(exec_req),
    .core_hold(core_hold), .sleep_exec(sleep_exec)
  );

  // pulses last one cycle, so latch them for the checks after entry and after wake
  always @(posedge pclk) begin
    if (res_p === 1'b1) seen_res = 1;
    if (rv_p === 1'b1) seen_rv = 1;
    if (adc_st === 1'b1) seen_adc = 1;
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    // only the watchdog ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task automatic sleep_now();
    @(posedge pclk); exec_req <= 1;
    @(posedge pclk); exec_req <= 0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic noop(input logic [7:0] v);
    logic [31:0] r;
    logic e;
    apb(1, mcu_control_addr, {24'h0, v}, r, e);
    sleep_now();
    chk("noop_hold", 0, core_hold);
  endtask

  task automatic run(input logic [2:0] code, input int s, input int bad,
                     input logic [6:0] en, input int d);
    int n;
    logic [31:0] r, v;
    logic e;
    v = {24'h0, 3'b001, code, 2'b01};
    apb(1, mcu_control_addr, v, r, e);
    seen_res = 0; seen_rv = 0; seen_adc = 0;
    sleep_now();
    chk("hold", 1, core_hold);
    chk("clk_en", en, ens);
    chk("adc_start", code <= 3'h1 && adc_en, seen_adc);
    if (bad >= 0) begin
      src[bad] <= 1'b1;
      repeat (30) @(posedge pclk);
      chk("no_wake", 1, core_hold);
      src[bad] <= 1'b0;
    end
    @(posedge pclk);
    src[s] <= 1'b1;
    n = 0;
    // sample the hold at the falling edge, where it has settled
    while (core_hold === 1'b1 && n < 300) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    src <= 8'h00;
    @(negedge pclk);
    chk("wake_dly", d + 2, n);
    chk("resume", s != 6, seen_res);
    chk("rst_vec", s == 6, seen_rv);
    chk("core_clk", 1, ce);
    apb(0, mcu_control_addr, 0, r, e);
    if (s != 6) chk("mcu_kept", v, r);
    apb(0, sleep_status_addr, 0, r, e);
    chk("status", {26'h0, s == 6, code, 2'b00}, r);
    apb(1, mcu_control_addr, 0, r, e);
    $display("test sleep mode %0d done", code);
  endtask

  task automatic test_done();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    test_done();
  end

  initial begin
    logic [31:0] r;
    logic e;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    chk("ens_rst", 7'h7e, ens);
    chk("hold_rst", 0, core_hold);
    apb(0, mcu_control_addr, 0, r, e);
    chk("mcu_rst", mcu_control_reset, r);
    apb(0, sleep_status_addr, 0, r, e);
    chk("stat_rst", 0, r);
    apb(1, mcu_control_addr, 32'h0000_00c3, r, e);
    apb(0, mcu_control_addr, 0, r, e);
    chk("mcu_rw", 32'h0000_00c3, r);
    apb(0, 8'h08, 0, r, e);
    chk("slverr", 1, e);
    $display("test registers done");
    noop(8'h00);
    noop({3'b001, kind_reserved_a, 2'b00});
    noop({3'b001, kind_reserved_b, 2'b00});
    noop({3'b001, kind_standby, 2'b00});
    noop({3'b001, kind_ext_standby, 2'b00});
    $display("test refused sleep done");
    @(posedge pclk); xtal <= 1;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk); gie <= (i != 6);
      adc_en <= (i != 7);
      run(t_code[i], t_src[i], t_bad[i], t_en[i],
          t_dly[i] + (t_src[i] >= 5 ? 2 : 0));
    end
    test_done();
  end
endmodule
